// ### verilog/wpi_pin_interface.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module wpi_pin_interface
   import wpi_pkg::*;
#(
   parameter int CLK_PERIOD_NS = 100
)
(
   // Clock and reset
   input  wire logic                  SYS_CLK_I,
   input  wire logic                  RST_N_I,
   // Register port
   input  wire wpi_pkg::wpi_reg_req_t REG_REQ_I,
   output logic [7:0]                 REG_RDATA_O,
   // Waveform engine side
   input  wire logic [5:0]            WAVE_CTRL_I,
   input  wire logic [5:0]            WAVE_CTRL_FLOAT_I,
   input  wire logic                  WAVE_DATA_DRIVE_I,
   input  wire logic [15:0]           WAVE_DATA_I,
   input  wire logic                  WAVE_ADDR_INC_I,
   input  wire logic [2:0]            WAVE_STATE_I,
   output logic [5:0]                 PACE_LEVEL_O,
   output logic [1:0]                 PACE_ACTION_O,
   output logic [15:0]                WAVE_DATA_O,
   // Control outputs
   output logic [5:0]                 CTRL_OUT_O,
   output logic [5:0]                 CTRL_OUT_OE_O,
   // Pace inputs
   input  wire logic [5:0]            PACE_IN_I,
   // Data bus
   input  wire logic [15:0]           FIFO_BUS_I,
   output logic [15:0]                FIFO_BUS_O,
   output logic [15:0]                FIFO_BUS_OE_O,
   // Address outputs
   output logic [8:0]                 WAVE_ADDR_OUT_O,
   output logic [8:0]                 WAVE_ADDR_OUT_OE_O,
   // Interface clock pin
   input  wire logic                  IFACE_CLOCK_I,
   output logic                       IFACE_CLOCK_O,
   output logic                       IFACE_CLOCK_OE_O,
   output logic                       IFACE_EDGE_O,
   // State number outputs
   output logic [2:0]                 STATE_NUM_OUT_O,
   output logic [2:0]                 STATE_NUM_OUT_OE_O
);
   import wpi_pkg::*;

   localparam int PACE_DLY_CYC_RAW = int'(PACE_DELAY_NS) / CLK_PERIOD_NS;
   localparam int PACE_DLY_CYC = (PACE_DLY_CYC_RAW < 1) ? 1 : PACE_DLY_CYC_RAW;

   typedef enum logic [2:0] {
      PA_CONTINUE = 3'b001,
      PA_WAIT     = 3'b010,
      PA_REPEAT   = 3'b100
   } wpi_pace_t;

   logic [7:0]  iface_config_r;
   logic [7:0]  control_output_config_r;
   logic [3:0]  endpoint_fifo_config_r;
   logic [8:0]  wave_addr_value_r;
   logic [7:0]  port_function_r;
   logic [7:0]  port_output_enable_r;
   logic [7:0]  wave_ctrl_r;
   logic [7:0]  port_b_a_r;
   logic [7:0]  port_d_b_r;
   logic [7:0]  rdata_r;
   logic [5:0]  pace_s1_r;
   logic [5:0]  pace_s2_r;
   logic [5:0]  pace_dly_r [PACE_DLY_CYC];
   logic [5:0]  pace_seen;
   logic [15:0] bus_s1_r;
   logic [15:0] bus_s2_r;
   logic [2:0]  clk_sync_r;
   logic        clk_edge;
   logic        clk_out_r;
   logic [5:0]  ctrl_o_r;
   logic [5:0]  ctrl_oe_r;
   logic [15:0] bus_o_r;
   logic [15:0] bus_oe_r;
   logic [8:0]  addr_oe_r;
   logic [2:0]  state_o_r;
   logic [2:0]  state_oe_r;
   wpi_pace_t   pace_act;
   logic        wave_mode;
   logic        wide_bus;
   logic        tri_mode;
   logic        open_drain;
   logic        wr_addr_l;
   logic        wr_addr_h;

   assign wave_mode  = iface_config_r[1:0] == IFC_FUNC_WAVE;
   assign wide_bus   = |endpoint_fifo_config_r;
   assign tri_mode   = control_output_config_r[CTL_TRISTATE_BIT];
   assign open_drain = !tri_mode && (|control_output_config_r[6:0]);
   assign wr_addr_l  = REG_REQ_I.wr && REG_REQ_I.addr == REG_WAVE_ADDR_L;
   assign wr_addr_h  = REG_REQ_I.wr && REG_REQ_I.addr == REG_WAVE_ADDR_H;

   // Configuration registers
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         iface_config_r          <= IFC_RESET;
         control_output_config_r <= CTL_CFG_RESET;
         endpoint_fifo_config_r  <= EP_WIDE_RESET;
         port_function_r         <= 8'h00;
         port_output_enable_r    <= 8'h00;
         wave_ctrl_r             <= 8'h00;
         port_b_a_r              <= 8'h00;
         port_d_b_r              <= 8'h00;
      end
      else if (REG_REQ_I.wr)
      begin
         case (REG_REQ_I.addr)
            REG_IFACE_CONFIG: iface_config_r          <= REG_REQ_I.wdata;
            REG_CTRL_OUT_CFG: control_output_config_r <= REG_REQ_I.wdata;
            REG_EP_FIFO_CFG:  endpoint_fifo_config_r  <= REG_REQ_I.wdata[3:0];
            REG_PORT_FUNC:    port_function_r         <= REG_REQ_I.wdata;
            REG_PORT_OE:      port_output_enable_r    <= REG_REQ_I.wdata;
            REG_WAVE_CTRL:    wave_ctrl_r             <= REG_REQ_I.wdata;
            REG_PORT_B_OUT:   port_b_a_r              <= REG_REQ_I.wdata;
            REG_PORT_D_OUT:   port_d_b_r              <= REG_REQ_I.wdata;
            default:          ;
         endcase
      end
   end

   // Address counter: software load beats an increment in the same cycle
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         wave_addr_value_r <= ADDR_RESET;
      else if (wr_addr_l)
         wave_addr_value_r <= {wave_addr_value_r[8], REG_REQ_I.wdata};
      else if (wr_addr_h)
         wave_addr_value_r <= {REG_REQ_I.wdata[0], wave_addr_value_r[7:0]};
      else if (wave_mode && clk_edge && WAVE_ADDR_INC_I)
         wave_addr_value_r <= wave_addr_value_r + 9'h001;
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rdata_r <= 8'h00;
      else if (REG_REQ_I.rd)
      begin
         case (REG_REQ_I.addr)
            REG_IFACE_CONFIG: rdata_r <= iface_config_r;
            REG_CTRL_OUT_CFG: rdata_r <= control_output_config_r;
            REG_EP_FIFO_CFG:  rdata_r <= {4'h0, endpoint_fifo_config_r};
            REG_WAVE_ADDR_L:  rdata_r <= wave_addr_value_r[7:0];
            REG_WAVE_ADDR_H:  rdata_r <= {7'h00, wave_addr_value_r[8]};
            REG_PORT_FUNC:    rdata_r <= port_function_r;
            REG_PORT_OE:      rdata_r <= port_output_enable_r;
            REG_WAVE_CTRL:    rdata_r <= wave_ctrl_r;
            REG_PACE_STATUS:  rdata_r <= {pace_act[2:1], pace_seen};
            REG_PORT_B_OUT:   rdata_r <= port_b_a_r;
            REG_PORT_D_OUT:   rdata_r <= port_d_b_r;
            REG_FIFO_BUS_IN:  rdata_r <= bus_s2_r[7:0];
            default:          rdata_r <= 8'h00;
         endcase
      end
      else
         rdata_r <= 8'h00;
   end
   assign REG_RDATA_O = rdata_r;

   // Interface clock pin sampled into the system clock domain
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         clk_sync_r <= 3'b000;
      else
         clk_sync_r <= {clk_sync_r[1:0], IFACE_CLOCK_I};
   end

   // Internal source toggles every system cycle, so an edge every two
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         clk_out_r <= 1'b0;
      else
         clk_out_r <= !clk_out_r;
   end

   always_comb
   begin
      if (iface_config_r[IFC_CLK_INT_BIT])
         clk_edge = !clk_out_r;
      else if (iface_config_r[IFC_CLK_INV_BIT])
         clk_edge = clk_sync_r[2] && !clk_sync_r[1];
      else
         clk_edge = !clk_sync_r[2] && clk_sync_r[1];
   end
   assign IFACE_EDGE_O     = clk_edge;
   assign IFACE_CLOCK_O    = clk_out_r ^ iface_config_r[IFC_CLK_INV_BIT];
   assign IFACE_CLOCK_OE_O = iface_config_r[IFC_CLK_INT_BIT]
                             && iface_config_r[IFC_CLK_OE_BIT];

   // Pace inputs: two-stage sync, then optional async delay line
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pace_s1_r <= 6'h00;
         pace_s2_r <= 6'h00;
         bus_s1_r  <= 16'h0000;
         bus_s2_r  <= 16'h0000;
      end
      else
      begin
         pace_s1_r <= PACE_IN_I;
         pace_s2_r <= pace_s1_r;
         bus_s1_r  <= FIFO_BUS_I;
         bus_s2_r  <= bus_s1_r;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (int i = 0; i < PACE_DLY_CYC; i++)
            pace_dly_r[i] <= 6'h00;
      end
      else
      begin
         pace_dly_r[0] <= pace_s2_r;
         for (int i = 1; i < PACE_DLY_CYC; i++)
            pace_dly_r[i] <= pace_dly_r[i-1];
      end
   end

   // Async sampling sees the older value
   assign pace_seen = iface_config_r[IFC_PACE_SYNC_BIT] ? pace_s2_r
                                                        : pace_dly_r[PACE_DLY_CYC-1];
   assign PACE_LEVEL_O = pace_seen;

   // Bit 0 held low waits, bit 1 low asks for a repeat, else continue
   always_comb
   begin
      if (!pace_seen[0])
         pace_act = PA_WAIT;
      else if (!pace_seen[1])
         pace_act = PA_REPEAT;
      else
         pace_act = PA_CONTINUE;
   end
   assign PACE_ACTION_O = {pace_act == PA_REPEAT, pace_act == PA_WAIT};

   // Read data lanes: low lane is the first byte of each pair
   assign WAVE_DATA_O = wide_bus ? bus_s2_r : {8'h00, bus_s2_r[7:0]};

   // Control outputs update once per interface clock edge
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ctrl_o_r  <= 6'h3F;
         ctrl_oe_r <= 6'h00;
      end
      else if (!wave_mode)
      begin
         ctrl_o_r  <= 6'h3F;
         ctrl_oe_r <= 6'h00;
      end
      else if (clk_edge)
      begin
         ctrl_o_r <= WAVE_CTRL_I;
         if (tri_mode)
            ctrl_oe_r <= {2'b00, ~WAVE_CTRL_FLOAT_I[3:0]};
         else if (open_drain)
            ctrl_oe_r <= ~WAVE_CTRL_I;
         else
            ctrl_oe_r <= 6'h3F;
      end
   end
   assign CTRL_OUT_O    = open_drain ? 6'h00 : ctrl_o_r;
   assign CTRL_OUT_OE_O = ctrl_oe_r;

   // Data bus lanes
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         bus_o_r  <= 16'h0000;
         bus_oe_r <= 16'h0000;
      end
      else if (!wave_mode)
      begin
         bus_o_r  <= {port_d_b_r, port_b_a_r};
         bus_oe_r <= {{8{port_output_enable_r[1]}}, {8{port_output_enable_r[0]}}};
      end
      else if (clk_edge)
      begin
         bus_o_r[7:0]  <= WAVE_DATA_I[7:0];
         bus_oe_r[7:0] <= {8{WAVE_DATA_DRIVE_I}};
         if (wide_bus)
         begin
            bus_o_r[15:8]  <= WAVE_DATA_I[15:8];
            bus_oe_r[15:8] <= {8{WAVE_DATA_DRIVE_I}};
         end
         else
         begin
            bus_o_r[15:8]  <= port_d_b_r;
            bus_oe_r[15:8] <= {8{port_output_enable_r[1]}};
         end
      end
   end
   assign FIFO_BUS_O    = bus_o_r;
   assign FIFO_BUS_OE_O = bus_oe_r;

   // Address outputs follow the counter directly
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         addr_oe_r <= 9'h000;
      else
         addr_oe_r <= {9{port_function_r[0] | port_output_enable_r[2]}};
   end
   assign WAVE_ADDR_OUT_O    = wave_addr_value_r;
   assign WAVE_ADDR_OUT_OE_O = addr_oe_r;

   // State number outputs override port E function bits
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_o_r  <= 3'h0;
         state_oe_r <= 3'h0;
      end
      else if (iface_config_r[IFC_STATE_OE_BIT])
      begin
         state_oe_r <= 3'h7;
         if (clk_edge)
            state_o_r <= WAVE_STATE_I;
      end
      else
      begin
         state_oe_r <= 3'h0;
         state_o_r  <= 3'h0;
      end
   end
   assign STATE_NUM_OUT_O    = state_o_r;
   assign STATE_NUM_OUT_OE_O = state_oe_r;

endmodule : wpi_pin_interface
`default_nettype wire

// ### verilog/wpi_pkg.sv
`default_nettype none
package wpi_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] REG_IFACE_CONFIG   = 4'h0;
   localparam logic [3:0] REG_CTRL_OUT_CFG   = 4'h1;
   localparam logic [3:0] REG_EP_FIFO_CFG    = 4'h2;
   localparam logic [3:0] REG_WAVE_ADDR_L    = 4'h3;
   localparam logic [3:0] REG_WAVE_ADDR_H    = 4'h4;
   localparam logic [3:0] REG_PORT_FUNC      = 4'h5;
   localparam logic [3:0] REG_PORT_OE        = 4'h6;
   localparam logic [3:0] REG_WAVE_CTRL      = 4'h7;
   localparam logic [3:0] REG_PACE_STATUS    = 4'h8;
   localparam logic [3:0] REG_PORT_B_OUT     = 4'h9;
   localparam logic [3:0] REG_PORT_D_OUT     = 4'hA;
   localparam logic [3:0] REG_FIFO_BUS_IN    = 4'hB;

   // iface_config fields
   localparam int IFC_CLK_INT_BIT   = 7;
   localparam int IFC_CLK_OE_BIT    = 5;
   localparam int IFC_CLK_INV_BIT   = 4;
   localparam int IFC_PACE_SYNC_BIT = 3;
   localparam int IFC_STATE_OE_BIT  = 2;
   localparam logic [1:0] IFC_FUNC_WAVE = 2'h2;
   localparam logic [7:0] IFC_RESET     = 8'h80;

   // control_output_config fields
   localparam int CTL_TRISTATE_BIT = 7;
   localparam logic [7:0] CTL_CFG_RESET = 8'h00;

   // endpoint FIFO config: wide bus bits per endpoint, default all set
   localparam logic [3:0] EP_WIDE_RESET = 4'hF;

   // wave control register fields
   localparam int WC_INC_BIT   = 7;
   localparam int WC_STATE_LSB = 0;

   localparam logic [8:0] ADDR_RESET = 9'h000;

   // Pace input async sample delay, 24 ns counted in system clock cycles, at least one
   localparam real PACE_DELAY_NS = 24.0;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } wpi_reg_req_t;

   typedef struct packed {
      logic [15:0] o;
      logic [15:0] oe;
   } wpi_bus_drive_t;

endpackage : wpi_pkg
`default_nettype wire

// ### tb/wpi_pin_interface_sva.sv
`timescale 1ns/1ps
`default_nettype none
module wpi_pin_interface_sva
   import wpi_pkg::*;
(
   // Clock and reset
   input wire logic                  SYS_CLK_I,
   input wire logic                  RST_N_I,
   // Watched pins
   input wire wpi_pkg::wpi_reg_req_t REG_REQ_I,
   input wire logic [5:0]            PACE_LEVEL_O,
   input wire logic [1:0]            PACE_ACTION_O,
   input wire logic [5:0]            CTRL_OUT_O,
   input wire logic [5:0]            CTRL_OUT_OE_O,
   input wire logic [8:0]            WAVE_ADDR_OUT_O,
   input wire logic                  IFACE_CLOCK_OE_O,
   input wire logic                  IFACE_EDGE_O,
   input wire logic [2:0]            STATE_NUM_OUT_OE_O
);
   logic [7:0] cfg_r;
   logic [7:0] ctl_r;
   logic [3:0] age_r;
   logic       wave;
   assign wave = (cfg_r[1:0] == IFC_FUNC_WAVE);
   // Age masks settling; an external edge can lag a write by eleven cycles
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         cfg_r <= IFC_RESET;
         ctl_r <= CTL_CFG_RESET;
         age_r <= 4'h0;
      end
      else
      begin
         if (REG_REQ_I.wr && REG_REQ_I.addr == REG_IFACE_CONFIG)
            cfg_r <= REG_REQ_I.wdata;
         if (REG_REQ_I.wr && REG_REQ_I.addr == REG_CTRL_OUT_CFG)
            ctl_r <= REG_REQ_I.wdata;
         if (REG_REQ_I.wr)
            age_r <= 4'h0;
         else if (age_r != 4'hF)
            age_r <= age_r + 4'h1;
      end
   end
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   AST_PORT_MODE: assert property (age_r > 4'hC && !wave |-> CTRL_OUT_OE_O == 6'h00)
      else $error("control pins driven in port mode");
   AST_WAVE_DRIVE: assert property (
      age_r > 4'hC && wave && ctl_r == 8'h00 |-> CTRL_OUT_OE_O == 6'h3F)
      else $error("push-pull control pins not driven");
   AST_OPEN_DRAIN: assert property (
      age_r > 4'hC && wave && !ctl_r[7] && ctl_r[5:0] != 6'h00 |-> (CTRL_OUT_O & ctl_r[5:0]) == 6'h00)
      else $error("open-drain pin shows a high value");
   AST_TRI_UPPER_OFF: assert property (
      age_r > 4'hC && wave && ctl_r[7] |-> CTRL_OUT_OE_O[5:4] == 2'b00)
      else $error("upper control pins driven in tristatable mode");
   AST_PACE_WAIT: assert property (!PACE_LEVEL_O[0] |-> PACE_ACTION_O == 2'b01)
      else $error("low pace level did not wait");
   AST_PACE_REPEAT: assert property (PACE_LEVEL_O[1:0] == 2'b01 |-> PACE_ACTION_O == 2'b10)
      else $error("pace level did not repeat");
   AST_INT_EDGE_RATE: assert property (
      age_r > 4'hC && cfg_r[7] |-> IFACE_EDGE_O != $past(IFACE_EDGE_O))
      else $error("internal edge not every second cycle");
   AST_CLK_PIN_OE: assert property (
      age_r > 4'hC |-> IFACE_CLOCK_OE_O == (cfg_r[7] && cfg_r[5]))
      else $error("interface clock pin direction wrong");
   AST_STATE_OE: assert property (age_r > 4'hC |-> STATE_NUM_OUT_OE_O == {3{cfg_r[2]}})
      else $error("state pin direction wrong");
   AST_ADDR_LOAD: assert property (
      REG_REQ_I.wr && REG_REQ_I.addr == REG_WAVE_ADDR_L
      |=> WAVE_ADDR_OUT_O[7:0] == $past(REG_REQ_I.wdata))
      else $error("address write not on pins at once");
endmodule : wpi_pin_interface_sva
bind wpi_pin_interface wpi_pin_interface_sva u_wpi_pin_interface_sva (.SYS_CLK_I, .RST_N_I,
   .REG_REQ_I, .PACE_LEVEL_O, .PACE_ACTION_O, .CTRL_OUT_O, .CTRL_OUT_OE_O, .WAVE_ADDR_OUT_O,
   .IFACE_CLOCK_OE_O, .IFACE_EDGE_O, .STATE_NUM_OUT_OE_O);
`default_nettype wire

// ### tb/wpi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module wpi_peer_model
(
   // Device pins
   input  wire logic        clk_i,
   input  wire logic [15:0] bus_o_i,
   input  wire logic [15:0] bus_oe_i,
   output logic [15:0]      bus_i_o,
   output logic             link_clk_o,
   output logic [5:0]       pace_o,
   // Bench commands
   input  wire logic        reply_en_i,
   input  wire logic [15:0] reply_i,
   input  wire logic [5:0]  pace_i
);
   logic [15:0] float_r = 16'hA5A5;
   // Free-running, off phase from the system clock
   initial
   begin
      link_clk_o = 1'b0;
      #30;
      forever #400 link_clk_o = ~link_clk_o;
   end
   // Released lanes wander so stale data never passes
   always @(posedge clk_i)
      float_r <= ~float_r;
   assign bus_i_o = (bus_oe_i & bus_o_i) | (~bus_oe_i & (reply_en_i ? reply_i : float_r));
   assign pace_o = pace_i;
endmodule : wpi_peer_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import wpi_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   wpi_reg_req_t req = '0;
   logic [7:0]   rdata;
   logic [5:0]   wctl = 6'h00, wflt = 6'h00, pace = 6'h3F, plv, ctl_o, ctl_oe, pace_in;
   logic         wdrv = 1'b0, winc = 1'b0, rep_en = 1'b0, clk_oe, edge_p, lclk, clk_pin;
   logic [2:0]   wst = 3'h5, st_o, st_oe;
   logic [1:0]   pact;
   logic [15:0]  wdat = 16'hB2A1, rep = 16'h5C3D, wd_in, bus_i, bus_o, bus_oe;
   logic [8:0]   adr, adr_oe;
   logic [5:0]   pv [3] = '{6'h3E, 6'h01, 6'h03};
   logic [1:0]   pa [3] = '{2'b01, 2'b10, 2'b00};
   logic [7:0]   fv [3] = '{8'h80, 8'h81, 8'h83};
   int           bad_count = 0, n_checks = 0, n0, n1;

   always #50 clk = ~clk;

   wpi_pin_interface u_wpi_pin_interface (.SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req),
      .REG_RDATA_O(rdata), .WAVE_CTRL_I(wctl), .WAVE_CTRL_FLOAT_I(wflt), .WAVE_DATA_DRIVE_I(wdrv),
      .WAVE_DATA_I(wdat), .WAVE_ADDR_INC_I(winc), .WAVE_STATE_I(wst), .PACE_LEVEL_O(plv),
      .PACE_ACTION_O(pact), .WAVE_DATA_O(wd_in), .CTRL_OUT_O(ctl_o), .CTRL_OUT_OE_O(ctl_oe),
      .PACE_IN_I(pace_in), .FIFO_BUS_I(bus_i), .FIFO_BUS_O(bus_o), .FIFO_BUS_OE_O(bus_oe),
      .WAVE_ADDR_OUT_O(adr), .WAVE_ADDR_OUT_OE_O(adr_oe), .IFACE_CLOCK_I(lclk),
      .IFACE_CLOCK_O(clk_pin), .IFACE_CLOCK_OE_O(clk_oe), .IFACE_EDGE_O(edge_p),
      .STATE_NUM_OUT_O(st_o), .STATE_NUM_OUT_OE_O(st_oe));

   wpi_peer_model u_wpi_peer_model (.clk_i(clk), .bus_o_i(bus_o), .bus_oe_i(bus_oe),
      .bus_i_o(bus_i), .link_clk_o(lclk), .pace_o(pace_in), .reply_en_i(rep_en),
      .reply_i(rep), .pace_i(pace));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // Idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      chk(16'(rdata), 16'(exp));
   endtask : rd

   task automatic edges(input int cyc, output int n);
      n = 0;
      repeat (cyc) @(negedge clk) n += int'(edge_p);
   endtask : edges

   // Starts just after an interface edge so both modes see the same phase
   task automatic lat(output int n);
      do
         @(negedge clk);
      while (edge_p !== 1'b1);
      @(posedge clk);
      pace <= ~pace;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (plv !== pace && n < 20);
   endtask : lat

   task automatic tally_and_finish;
      if (bad_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #300000;
      bad_count++;
      tally_and_finish;
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      settle(1);
      chk(16'(ctl_o), 16'h003F);
      chk({ctl_oe, st_oe, clk_oe, adr_oe[5:0]}, 16'h0000);
      chk(bus_oe, 16'h0000);
      rd(REG_IFACE_CONFIG, IFC_RESET);
      rd(REG_EP_FIFO_CFG, {4'h0, EP_WIDE_RESET});
      rd(REG_CTRL_OUT_CFG, CTL_CFG_RESET);
      rd(4'hF, 8'h00);
      wr(REG_PORT_FUNC, 8'h01);
      wr(REG_PORT_OE, 8'h04);
      wr(REG_WAVE_ADDR_H, 8'h01);
      wr(REG_WAVE_ADDR_L, 8'hA5);
      settle(1);
      chk({adr_oe[6:0], adr}, 16'hFFA5);
      wr(REG_PORT_FUNC, 8'h00);
      wr(REG_PORT_OE, 8'h00);
      settle(1);
      chk(16'(adr_oe), 16'h0000);
      @(posedge clk);
      wctl <= 6'h2A;
      wdrv <= 1'b1;
      wr(REG_IFACE_CONFIG, 8'hA6);
      settle(16);
      chk({4'h0, ctl_oe, ctl_o}, 16'h0FEA);
      chk(16'({st_oe, st_o, clk_oe}), 16'h007B);
      chk(bus_o, 16'hB2A1);
      chk(bus_oe, 16'hFFFF);
      edges(20, n0);
      chk(16'(n0), 16'h000A);
      // Internal clock driven out must toggle every system cycle
      @(negedge clk);
      n1 = int'(clk_pin);
      @(negedge clk);
      chk(16'(clk_pin), 16'(n1 == 0));
      foreach (pv[i])
      begin
         @(posedge clk);
         pace <= pv[i];
         settle(6);
         chk(16'({pact, plv}), {8'h00, pa[i], pv[i]});
      end
      lat(n0);
      wr(REG_IFACE_CONFIG, 8'hAE);
      settle(16);
      lat(n1);
      chk(16'(n0 - n1), 16'h0001);
      wr(REG_PORT_FUNC, 8'h01);
      wr(REG_PORT_OE, 8'h04);
      wr(REG_WAVE_ADDR_L, 8'hFF);
      winc <= 1'b1;
      repeat (4) @(posedge clk);
      winc <= 1'b0;
      settle(4);
      chk(16'(adr), 16'h0001);
      wr(REG_EP_FIFO_CFG, 8'h00);
      settle(16);
      chk(bus_oe, 16'h00FF);
      @(posedge clk);
      wdrv <= 1'b0;
      rep_en <= 1'b1;
      settle(8);
      chk(wd_in, 16'h003D);
      wr(REG_EP_FIFO_CFG, 8'h04);
      settle(16);
      chk(wd_in, 16'h5C3D);
      @(posedge clk);
      wflt <= 6'h05;
      wr(REG_CTRL_OUT_CFG, 8'h80);
      settle(16);
      chk(16'(ctl_oe), 16'h000A);
      @(posedge clk);
      wctl <= 6'h30;
      wr(REG_CTRL_OUT_CFG, 8'h3F);
      settle(16);
      chk({4'h0, ctl_oe, ctl_o}, 16'h03C0);
      rd(REG_CTRL_OUT_CFG, 8'h3F);
      foreach (fv[i])
      begin
         wr(REG_IFACE_CONFIG, fv[i]);
         settle(16);
         chk(16'(ctl_oe), 16'h0000);
      end
      wr(REG_IFACE_CONFIG, 8'h22);
      settle(16);
      chk(16'(clk_oe), 16'h0000);
      edges(80, n0);
      chk(16'(n0), 16'h000A);
      tally_and_finish;
   end
endmodule : tb_top
`default_nettype wire
